// ### dop_pacer.sv
// Purpose: DAC output pacing, start trigger and sample steering
// Assumes: APB slave, pclk 100 MHz, pins asynchronous
// Notes: No wait states except a data write to a full FIFO; refill request is a plain output level
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dop_pacer
  import dop_pkg::*;
#(
  parameter int FIFO_DEPTH = dop_pkg::DOP_FIFO_DEPTH
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [dop_pkg::DOP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          ext_pace_input,
  input  wire logic                          ext_start_trigger_input,
  output logic      [dop_pkg::DOP_CODE_W-1:0] dac0_code,
  output logic      [dop_pkg::DOP_CODE_W-1:0] dac1_code,
  output logic                               dac0_load,
  output logic                               dac1_load,
  output logic                               refill_req,
  output logic                               underrun
);
  import dop_pkg::*;

  typedef enum logic [1:0] {DOP_IDLE, DOP_ARMED, DOP_RUN} dop_state_t;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  dop_state_t               st_ff;
  dop_state_t               nxt_st;
  logic [DOP_CTRL_W-1:0]    ctrl_ff;
  logic [DOP_CTRL_W-1:0]    nxt_ctrl;
  logic [DOP_DIV_W-1:0]     div_ff;
  logic [DOP_DIV_W-1:0]     nxt_div;
  logic                     sflag_ff;
  logic                     nxt_sflag;
  logic [3:0]               base_ff;
  logic [3:0]               nxt_base;
  logic [DOP_DIV_W-1:0]     cnt_ff;
  logic [DOP_DIV_W-1:0]     nxt_cnt;
  logic                     dout_ff;
  logic                     nxt_dout;
  logic [2:0]               pace_sy_ff;
  logic [2:0]               trg_sy_ff;
  logic                     odd_ff;
  logic                     nxt_odd;
  logic [DOP_CODE_W-1:0]    d0_ff;
  logic [DOP_CODE_W-1:0]    nxt_d0;
  logic [DOP_CODE_W-1:0]    d1_ff;
  logic [DOP_CODE_W-1:0]    nxt_d1;
  logic                     l0_ff;
  logic                     nxt_l0;
  logic                     l1_ff;
  logic                     nxt_l1;
  logic                     und_ff;
  logic                     nxt_und;
  logic [31:0]              rd_ff;
  logic [31:0]              nxt_rd;
  logic                     wr_en;
  logic                     rd_en;
  logic                     base_tick;
  logic                     int_rise;
  logic                     ext_rise;
  logic                     pace_edge;
  logic                     trg_edge;
  logic                     soft_edge;
  logic                     trig_evt;
  logic                     f_in_valid;
  logic                     f_in_ready;
  logic                     f_out_valid;
  logic                     f_out_ready;
  logic [DOP_CODE_W-1:0]    f_out_data;
  logic [LW-1:0]            f_level;

  function automatic logic edge_of(input logic prev, input logic cur, input logic fall);
    edge_of = fall ? (prev && !cur) : (!prev && cur);
  endfunction

  // Pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pace_sy_ff <= '0;
      trg_sy_ff  <= '0;
    end
    else
    begin
      pace_sy_ff <= {pace_sy_ff[1:0], ext_pace_input};
      trg_sy_ff  <= {trg_sy_ff[1:0], ext_start_trigger_input};
    end
  end

  assign ext_rise = edge_of(pace_sy_ff[2], pace_sy_ff[1], 1'b0);
  assign trg_edge = edge_of(trg_sy_ff[2], trg_sy_ff[1], ctrl_ff[DOP_CTRL_FALL]);

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Soft trigger edge: flag toggles to the written value, edge matches polarity
  assign soft_edge = wr_en && (paddr == DOP_TRIG_OFS)
                     && edge_of(sflag_ff, pwdata[0], ctrl_ff[DOP_CTRL_FALL]);

  assign trig_evt = ctrl_ff[DOP_CTRL_EXT_TRG] ? trg_edge : soft_edge;

  assign base_tick = (base_ff == 4'(DOP_BASE_CYC - 1));
  assign int_rise  = base_tick && (cnt_ff == '0) && !dout_ff;
  assign pace_edge = ctrl_ff[DOP_CTRL_EXT_CLK] ? ext_rise : int_rise;

  // Divider: 10 MHz base, 16-bit reload, output high for the first half
  always_comb
  begin
    nxt_base = base_tick ? 4'h0 : base_ff + 4'h1;
    nxt_cnt  = cnt_ff;
    nxt_dout = dout_ff;
    if (st_ff == DOP_IDLE)
    begin
      nxt_cnt  = '0;
      nxt_dout = 1'b0;
    end
    else if (base_tick)
    begin
      nxt_cnt  = (cnt_ff == '0) ? div_ff - 16'h0001 : cnt_ff - 16'h0001;
      nxt_dout = (cnt_ff == '0) ? 1'b1 : (cnt_ff > (div_ff >> 1)) ? dout_ff : 1'b0;
    end
  end

  // Run state: pacing counts once armed; samples drain only after the trigger
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      DOP_IDLE:
        if (ctrl_ff[DOP_CTRL_RUN])
          nxt_st = DOP_ARMED;
      DOP_ARMED:
        if (!ctrl_ff[DOP_CTRL_RUN])
          nxt_st = DOP_IDLE;
        else if (trig_evt)
          nxt_st = DOP_RUN;
      DOP_RUN:
        if (!ctrl_ff[DOP_CTRL_RUN])
          nxt_st = DOP_IDLE;
    endcase
  end

  // Drain: one sample per pacing edge, interleaved when both channels run
  assign f_out_ready = (st_ff == DOP_RUN) && pace_edge;
  always_comb
  begin
    nxt_odd = odd_ff;
    nxt_d0  = d0_ff;
    nxt_d1  = d1_ff;
    nxt_l0  = 1'b0;
    nxt_l1  = 1'b0;
    nxt_und = und_ff && !(wr_en && paddr == DOP_STAT_OFS);
    if (st_ff == DOP_IDLE)
    begin
      nxt_odd = 1'b0;
    end
    if (f_out_ready && !f_out_valid)
    begin
      nxt_und = 1'b1;
    end
    if (f_out_ready && f_out_valid)
    begin
      if (ctrl_ff[DOP_CTRL_CH0_EN] && ctrl_ff[DOP_CTRL_CH1_EN])
      begin
        nxt_odd = !odd_ff;
        if (odd_ff)
        begin
          nxt_d1 = f_out_data;
          nxt_l1 = 1'b1;
        end
        else
        begin
          nxt_d0 = f_out_data;
          nxt_l0 = 1'b1;
        end
      end
      else if (ctrl_ff[DOP_CTRL_CH1_EN])
      begin
        nxt_d1 = f_out_data;
        nxt_l1 = 1'b1;
      end
      else
      begin
        nxt_d0 = f_out_data;
        nxt_l0 = ctrl_ff[DOP_CTRL_CH0_EN];
      end
    end
  end

  // Register writes and reads
  assign f_in_valid = wr_en && (paddr == DOP_DATA_OFS);
  always_comb
  begin
    nxt_ctrl  = ctrl_ff;
    nxt_div   = div_ff;
    nxt_sflag = sflag_ff;
    if (wr_en)
    begin
      unique case (paddr)
        DOP_CTRL_OFS: nxt_ctrl = pwdata[DOP_CTRL_W-1:0];
        // Hardware keeps the divisor at or above DOP_DIV_MIN; too small clamps to the top rate
        DOP_DIV_OFS:  nxt_div = (pwdata[15:0] < 16'(DOP_DIV_MIN)) ? 16'(DOP_DIV_MIN) : pwdata[15:0];
        DOP_TRIG_OFS: nxt_sflag = pwdata[0];
        default: ;
      endcase
    end
    nxt_rd = rd_ff;
    if (rd_en)
    begin
      unique case (paddr)
        DOP_CTRL_OFS: nxt_rd = {26'h0, ctrl_ff};
        DOP_DIV_OFS:  nxt_rd = {16'h0, div_ff};
        DOP_TRIG_OFS: nxt_rd = {31'h0, sflag_ff};
        DOP_STAT_OFS: nxt_rd = {16'h0, (16-LW)'(0), f_level} | {27'h0, und_ff, refill_req,
                                st_ff == DOP_RUN, st_ff == DOP_ARMED, 1'b0} << 16;
        DOP_OUT_OFS:  nxt_rd = {4'h0, d1_ff, 4'h0, d0_ff};
        default:      nxt_rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff    <= DOP_IDLE;
      ctrl_ff  <= DOP_CTRL_RST;
      div_ff   <= DOP_DIV_RST;
      sflag_ff <= 1'b0;
      base_ff  <= 4'h0;
      cnt_ff   <= '0;
      dout_ff  <= 1'b0;
      odd_ff   <= 1'b0;
      d0_ff    <= DOP_CODE_MID;
      d1_ff    <= DOP_CODE_MID;
      l0_ff    <= 1'b0;
      l1_ff    <= 1'b0;
      und_ff   <= 1'b0;
      rd_ff    <= 32'h0000_0000;
    end
    else
    begin
      st_ff    <= nxt_st;
      ctrl_ff  <= nxt_ctrl;
      div_ff   <= nxt_div;
      sflag_ff <= nxt_sflag;
      base_ff  <= nxt_base;
      cnt_ff   <= nxt_cnt;
      dout_ff  <= nxt_dout;
      odd_ff   <= nxt_odd;
      d0_ff    <= nxt_d0;
      d1_ff    <= nxt_d1;
      l0_ff    <= nxt_l0;
      l1_ff    <= nxt_l1;
      und_ff   <= nxt_und;
      rd_ff    <= nxt_rd;
    end
  end

  dop_fifo #(
    .WIDTH (DOP_CODE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (pwdata[DOP_CODE_W-1:0]),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // Full FIFO stalls the data write until a sample drains
  assign pready     = !(psel && penable && pwrite && (paddr == DOP_DATA_OFS) && !f_in_ready);
  assign pslverr    = 1'b0;
  assign prdata     = rd_ff;
  assign refill_req = (f_level < LW'(FIFO_DEPTH / 2));
  assign underrun   = und_ff;
  assign dac0_code  = d0_ff;
  assign dac1_code  = d1_ff;
  assign dac0_load  = l0_ff;
  assign dac1_load  = l1_ff;
endmodule
`default_nettype wire

// ### dop_pkg.sv
// Purpose: Constants for the DAC output pacing and trigger block
// Assumes: APB, 32-bit data, pclk 100 MHz, pacing time base 10 MHz
// Notes: Offsets are byte addresses; the trigger flag keeps its word index 0Ah
package dop_pkg;
  localparam logic [7:0]  DOP_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  DOP_DIV_OFS      = 8'h04;
  localparam logic [7:0]  DOP_TRIG_IDX     = 8'h0A;
  localparam logic [7:0]  DOP_TRIG_OFS     = {DOP_TRIG_IDX[5:0], 2'b00};
  localparam logic [7:0]  DOP_DATA_OFS     = 8'h0C;
  localparam logic [7:0]  DOP_STAT_OFS     = 8'h10;
  localparam logic [7:0]  DOP_OUT_OFS      = 8'h14;
  localparam int          DOP_ADDR_W       = 8;
  localparam int          DOP_CTRL_EXT_CLK = 0;
  localparam int          DOP_CTRL_EXT_TRG = 1;
  localparam int          DOP_CTRL_FALL    = 2;
  localparam int          DOP_CTRL_CH0_EN  = 3;
  localparam int          DOP_CTRL_CH1_EN  = 4;
  localparam int          DOP_CTRL_RUN     = 5;
  localparam int          DOP_CTRL_W       = 6;
  localparam logic [5:0]  DOP_CTRL_RST     = 6'h00;
  localparam int          DOP_CODE_W       = 12;
  localparam logic [11:0] DOP_CODE_MID     = 12'h800;
  localparam int          DOP_DIV_W        = 16;
  localparam logic [15:0] DOP_DIV_RST      = 16'h000A;
  localparam int          DOP_DIV_MIN      = 10;
  localparam int          DOP_CLK_HZ       = 100000000;
  localparam int          DOP_BASE_HZ      = 10000000;
  localparam int          DOP_BASE_CYC     = DOP_CLK_HZ / DOP_BASE_HZ;
  localparam int          DOP_FIFO_DEPTH   = 16;
endpackage

// ### dop_fifo.sv
// Purpose: Sample FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes: Read data registered
`timescale 1ns/10ps
`default_nettype none
module dop_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    nxt_wp;
  logic [AW-1:0]    rp_ff;
  logic [AW-1:0]    nxt_rp;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic [WIDTH-1:0] dat_ff;
  logic [WIDTH-1:0] nxt_dat;
  logic             vld_ff;
  logic             nxt_vld;
  logic             push;
  logic             pop;
  logic [AW:0]      avail;

  // Head word is held in dat_ff; mem holds the rest
  always_comb
  begin
    in_ready = (cnt_ff != (AW+1)'(DEPTH));
    push     = in_valid && in_ready;
    pop      = vld_ff && out_ready;
    // Words still in mem; the head word must not be counted twice
    avail    = cnt_ff - (AW+1)'(vld_ff);
    nxt_wp   = wp_ff;
    nxt_rp   = rp_ff;
    nxt_cnt  = cnt_ff;
    nxt_dat  = dat_ff;
    nxt_vld  = vld_ff;
    if (push)
    begin
      nxt_wp = wp_ff + 1'b1;
    end
    if ((!vld_ff || pop) && ((avail != '0) || push))
    begin
      nxt_vld = 1'b1;
      nxt_dat = (avail == '0) ? in_data : mem_ff[rp_ff];
      nxt_rp  = rp_ff + 1'b1;
    end
    else if (pop)
    begin
      nxt_vld = 1'b0;
    end
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
      dat_ff <= '0;
      vld_ff <= 1'b0;
    end
    else
    begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
      dat_ff <= nxt_dat;
      vld_ff <= nxt_vld;
    end
  end

  assign out_valid = vld_ff;
  assign out_data  = dat_ff;
  assign level     = cnt_ff;
endmodule
`default_nettype wire

// ### dop_pacer_monitor.sv
// Purpose: Port checks for the DAC pacing block
// Assumes: One pclk domain
// Notes: Bound to every dop_pacer
`timescale 1ns/10ps
`default_nettype none
module dop_pacer_monitor
  import dop_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] dac0_code,
  input wire logic [11:0] dac1_code,
  input wire logic        dac0_load,
  input wire logic        dac1_load,
  input wire logic        refill_req,
  input wire logic        underrun
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence data_wr_s;
    psel && penable && pwrite && paddr == DOP_DATA_OFS;
  endsequence
  sequence any_load_s;
    dac0_load || dac1_load;
  endsequence
  load_pulse_a: assert property (dac0_load |=> !dac0_load)
    else $error("load longer than one cycle");
  load_gap_a: assert property (any_load_s |=> !(dac0_load || dac1_load) [*3])
    else $error("loads too close");
  load_excl_a: assert property (!(dac0_load && dac1_load))
    else $error("both channels loaded at once");
  code0_hold_a: assert property ($changed(dac0_code) |-> dac0_load)
    else $error("code 0 moved without load");
  code1_hold_a: assert property ($changed(dac1_code) |-> dac1_load)
    else $error("code 1 moved without load");
  zero_wait_a: assert property (psel && penable && !(pwrite && paddr == DOP_DATA_OFS) |-> pready)
    else $error("wait state on register access");
  full_stall_a: assert property (data_wr_s ##0 !pready |-> !refill_req)
    else $error("stall while refill requested");
  under_hold_a: assert property (underrun && !(psel && penable && pwrite && paddr == DOP_STAT_OFS)
    |=> underrun)
    else $error("underrun lost");
  no_error_a: assert property (!pslverr)
    else $error("error response");
endmodule
bind dop_pacer dop_pacer_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .dac0_code(dac0_code),
  .dac1_code(dac1_code), .dac0_load(dac0_load), .dac1_load(dac1_load), .refill_req(refill_req),
  .underrun(underrun));
`default_nettype wire

// ### dop_ext_src.sv
// Purpose: External pace and trigger pin source
// Assumes: Pins change just after pclk edges
// Notes: Pace high 3 and low 5 cycles between pulses, above sync minimum
`timescale 1ns/10ps
`default_nettype none
module dop_ext_src (
  input  wire logic pclk,
  output logic      pace,
  output logic      trig
);
  initial
  begin
    pace = 1'b0;
    trig = 1'b0;
  end
  task automatic pace_n(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      pace <= 1'b1;
      repeat (3) @(posedge pclk);
      pace <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic trig_to(input logic v);
    @(posedge pclk);
    trig <= v;
    repeat (6) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ### dop_pacer_bench.sv
// Purpose: Self-checking bench for dop_pacer
// Assumes: Queue model of the FIFO and channel order
// Notes: FIFO depth 16, the package default
`timescale 1ns/10ps
`default_nettype none
module dop_pacer_bench;
  import dop_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pace, trig, d0l, d1l, refill, under;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [11:0] d0c, d1c;
  int          err_total, compares, ch, n, e;
  logic [11:0] lastc [2];
  bit          both;
  int          q[$];
  dop_pacer #(.FIFO_DEPTH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pace_input(pace), .ext_start_trigger_input(trig), .dac0_code(d0c), .dac1_code(d1c),
    .dac0_load(d0l), .dac1_load(d1l), .refill_req(refill), .underrun(under));
  dop_ext_src src (.pclk(pclk), .pace(pace), .trig(trig));
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 300);
    if (pready !== 1'b1)
    begin
      err_total++;
      $display("MISMATCH t=%0t bus wait timeout", $time);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic push(input int m);
    logic [31:0] v;
    repeat (m)
    begin
      v = xs();
      q.push_back(int'(v[11:0]));
      apb(1'b1, DOP_DATA_OFS, v);
    end
  endtask
  task automatic wait_load();
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (d1l !== 1'b1 && n < 5000);
    if (d1l !== 1'b1)
    begin
      err_total++;
      $display("MISMATCH t=%0t load wait timeout", $time);
    end
  endtask
  task automatic summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Every load is scored against the queue model
  always @(posedge pclk)
    if (presetn === 1'b1 && (d0l === 1'b1 || d1l === 1'b1))
    begin
      e = q.size() ? q.pop_front() : -1;
      chk({31'h0, d1l}, ch);
      chk(ch ? d1c : d0c, e);
      lastc[ch] = e[11:0];
      if (both)
        ch ^= 1;
    end
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #400000;
    err_total++;
    summarize();
  end
  initial
  begin
    rnd = 32'h0000_2FBE;
    {presetn, psel, penable, pwrite, paddr, pwdata, both, ch} = '0;
    lastc = '{DOP_CODE_MID, DOP_CODE_MID};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(d0c, DOP_CODE_MID);
    chk(refill, 1);
    apb(1'b0, DOP_DIV_OFS, xs());
    chk(rd, 32'h0A);
    apb(1'b1, DOP_DIV_OFS, xs() & 32'hFFFF_0007);
    apb(1'b0, DOP_DIV_OFS, xs());
    chk(rd, DOP_DIV_MIN);
    apb(1'b0, 8'hFC, xs());
    chk(rd, 0);
    both = 1;
    push(4);
    apb(1'b1, DOP_CTRL_OFS, 32'h39);
    src.pace_n(2);
    apb(1'b0, DOP_STAT_OFS, xs());
    chk(rd[17:0], 32'h20004);
    apb(1'b1, DOP_TRIG_OFS, 1);
    src.pace_n(4);
    chk(q.size(), 0);
    apb(1'b1, DOP_CTRL_OFS, 0);
    both = 0;
    push(3);
    apb(1'b1, DOP_CTRL_OFS, 32'h2F);
    src.trig_to(1'b1);
    src.pace_n(1);
    apb(1'b0, DOP_STAT_OFS, xs());
    chk(rd[4:0], 3);
    src.trig_to(1'b0);
    src.pace_n(4);
    chk(under, 1);
    apb(1'b1, DOP_STAT_OFS, xs());
    chk(under, 0);
    apb(1'b1, DOP_CTRL_OFS, 0);
    ch = 1;
    push(2);
    apb(1'b1, DOP_DIV_OFS, 12);
    apb(1'b1, DOP_CTRL_OFS, 32'h30);
    apb(1'b1, DOP_TRIG_OFS, 0);
    apb(1'b1, DOP_TRIG_OFS, 1);
    wait_load();
    wait_load();
    chk(n, 120);
    apb(1'b1, DOP_CTRL_OFS, 0);
    ch = 0;
    push(16);
    chk(refill, 0);
    apb(1'b1, DOP_CTRL_OFS, 32'h29);
    apb(1'b1, DOP_TRIG_OFS, 0);
    apb(1'b1, DOP_TRIG_OFS, 1);
    fork
      push(1);
      begin
        repeat (8) @(posedge pclk);
        chk(pready, 0);
        src.pace_n(1);
      end
    join
    src.pace_n(16);
    chk(refill, 1);
    chk(q.size(), 0);
    apb(1'b0, DOP_OUT_OFS, xs());
    chk(rd, {4'h0, lastc[1], 4'h0, lastc[0]});
    summarize();
  end
endmodule
`default_nettype wire
